//--- hw/hrt_regs.svh
// Register map, field positions, reset values and timing constants of the timer core
// Contract
// - Regulated generator: 8 or 16 events per clock
// - Regulation enable starts tracking the input clock
// - Lock flag on lock; unlock flag while unlocked
// - Out of range sets fail-high or fail-low
// - Regulation off returns free-run, settings kept
// - Counter advances only when mode nonzero, clock active
// - Zero period halts; nonzero restarts from zero
// - Mode codes: stop, up, continuous, up/down
// - Up mode wraps after period, restarts if above
// - Up mode: compare at period, overflow at wrap
// - Immediate reload below count wraps to zero
// - Hi-res ignores low 4 or 3 period bits
// - Continuous counts to length maximum, overflow on wrap
// - Up/down counts up to period and back
// - Period above maximum behaves as continuous
// - Direction held; software clear resets count, direction, divider
// - Up/down: compare at period, overflow 1 to 0
// - Length 8, 10, 12 or 16 bits
// - Multiplier code 00 is 8x, 01 is 16x
`ifndef HRT_REGS_SVH
`define HRT_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HRT_ADDR_W 4
`define HRT_OFF_CTRL 4'h0
`define HRT_OFF_PERIOD 4'h1
`define HRT_OFF_COUNT 4'h2
`define HRT_OFF_STATUS 4'h3
`define HRT_OFF_HRCTL 4'h4
`define HRT_OFF_HRTUNE 4'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define HRT_CTRL_MODE_LSB 0
`define HRT_CTRL_LEN_LSB 2
`define HRT_CTRL_CLR_BIT 4
`define HRT_CTRL_DIV_LSB 5
`define HRT_ST_OVF_BIT 0
`define HRT_ST_CMP_BIT 1
`define HRT_ST_LOCK_BIT 2
`define HRT_ST_UNLOCK_BIT 3
`define HRT_ST_FH_BIT 4
`define HRT_ST_FL_BIT 5
`define HRT_ST_DIR_BIT 8
`define HRT_HR_EN_BIT 0
`define HRT_HR_REG_BIT 1
`define HRT_HR_MUL_BIT 2
`define HRT_TUNE_TRIM_LSB 0
`define HRT_TUNE_SR_LSB 7
`define HRT_TUNE_R_LSB 12

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define HRT_TRIM_RST 7'h40
`define HRT_SR_RST 5'h00
`define HRT_R_RST 2'h0
`define HRT_MAX8 16'h00FF
`define HRT_MAX10 16'h03FF
`define HRT_MAX12 16'h0FFF
`define HRT_MAX16 16'hFFFF
`define HRT_EV_8X 5'h08
`define HRT_EV_16X 5'h10
`define HRT_LOCK_TOL 8'h01
`define HRT_LOCK_TIME_NS 64
`define HRT_CLK_NS 4
`define HRT_LOCK_CYC ((`HRT_LOCK_TIME_NS + `HRT_CLK_NS - 1) / `HRT_CLK_NS)

`endif

//--- hw/hrt_pkg.sv
// Types shared by the timer core
package hrt_pkg;
  typedef enum logic [1:0] {HRT_STOP, HRT_UP, HRT_CONT, HRT_UPDOWN} hrt_mode_t;
  typedef enum logic [1:0] {HRT_LEN16, HRT_LEN12, HRT_LEN10, HRT_LEN8} hrt_len_t;
  typedef enum logic [1:0] {HRT_FREE, HRT_TRACK, HRT_LOCKED} hrt_gen_state_t;
endpackage

//--- hw/hrt_hires_gen.sv
// High-resolution generator model: free-run or regulated tick source with lock status
`timescale 1ns/1ps
`default_nettype none
`include "hrt_regs.svh"
module hrt_hires_gen
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic regulate,
  input wire logic mul16,
  input wire logic ref_edge,
  input wire logic [7:0] fast_per_ref,
  input wire logic range_ok_hi,
  input wire logic range_ok_lo,
  output logic locked,
  output logic lock_event,
  output logic fail_hi_event,
  output logic fail_lo_event
);
  import hrt_pkg::*;

  hrt_gen_state_t state;
  hrt_gen_state_t next_state;
  logic [7:0] settle;
  logic [7:0] next_settle;
  logic [7:0] target;
  logic [7:0] err;

  // ----------------------------------------
  // Regulation loop
  // ----------------------------------------
  always_comb
  begin
    target = mul16 ? {3'h0, `HRT_EV_16X} : {3'h0, `HRT_EV_8X};
    err = (fast_per_ref > target) ? fast_per_ref - target : target - fast_per_ref;
    next_state = state;
    next_settle = settle;
    lock_event = 1'b0;
    fail_hi_event = 1'b0;
    fail_lo_event = 1'b0;
    case (state)
      HRT_FREE:
      begin
        next_settle = 8'h00;
        if (enable && regulate)
        begin
          next_state = HRT_TRACK;
        end
      end
      HRT_TRACK, HRT_LOCKED:
      begin
        if (!(enable && regulate))
        begin
          next_state = HRT_FREE;
        end
        else if (ref_edge)
        begin
          fail_hi_event = !range_ok_hi;
          fail_lo_event = !range_ok_lo;
          if (err <= `HRT_LOCK_TOL && range_ok_hi && range_ok_lo)
          begin
            if (state == HRT_TRACK && settle >= 8'(`HRT_LOCK_CYC))
            begin
              next_state = HRT_LOCKED;
              lock_event = 1'b1;
            end
            else
            begin
              next_settle = settle + 8'h01;
            end
          end
          else
          begin
            // Keeps tracking later input clock changes
            next_state = HRT_TRACK;
            next_settle = 8'h00;
          end
        end
      end
      default:
      begin
        next_state = HRT_FREE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= HRT_FREE;
      settle <= 8'h00;
    end
    else
    begin
      state <= next_state;
      settle <= next_settle;
    end
  end

  assign locked = (state == HRT_LOCKED);
endmodule
`default_nettype wire

//--- hw/hrt_core.sv
// Timer counter core with mode control and high-resolution generator status
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hrt_regs.svh"
module hrt_core
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [`HRT_ADDR_W-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic TCLK_TICK,
  input wire logic [7:0] HR_FAST_PER_REF,
  input wire logic HR_RANGE_OK_HI,
  input wire logic HR_RANGE_OK_LO,
  output logic OVERFLOW_EVT,
  output logic COMPARE0_EVT,
  output logic EVENT_PENDING,
  output logic [15:0] COUNT_OUT,
  output logic HR_LOCKED
);
  import hrt_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  hrt_mode_t count_mode_select;
  hrt_len_t counter_length;
  logic [2:0] divider_select;
  logic [15:0] period_latch;
  logic [15:0] count;
  logic count_down;
  logic [7:0] div_cnt;
  logic hr_mode_enable;
  logic hr_regulation_enable;
  logic hr_multiplier;
  logic [6:0] hr_trim;
  logic [4:0] hr_subrange;
  logic [1:0] hr_range;
  logic overflow_flag;
  logic channel_zero_compare_flag;
  logic hr_lock_flag;
  logic hr_fail_high_flag;
  logic hr_fail_low_flag;

  hrt_mode_t next_count_mode_select;
  hrt_len_t next_counter_length;
  logic [2:0] next_divider_select;
  logic [15:0] next_period_latch;
  logic [15:0] next_count;
  logic next_count_down;
  logic [7:0] next_div_cnt;
  logic next_hr_mode_enable;
  logic next_hr_regulation_enable;
  logic next_hr_multiplier;
  logic [6:0] next_hr_trim;
  logic [4:0] next_hr_subrange;
  logic [1:0] next_hr_range;
  logic next_overflow_flag;
  logic next_channel_zero_compare_flag;
  logic next_hr_lock_flag;
  logic next_hr_fail_high_flag;
  logic next_hr_fail_low_flag;
  logic [15:0] next_rdata;
  logic next_ovf_evt;
  logic next_cmp_evt;

  logic [15:0] length_maximum;
  logic [15:0] eff_period;
  logic tick;
  logic ovf_ev;
  logic cmp_ev;
  logic gen_locked;
  logic gen_lock_ev;
  logic gen_fh_ev;
  logic gen_fl_ev;
  logic sw_clear;
  logic wr_ctrl;
  logic wr_status;

  hrt_hires_gen u_gen
  (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .enable(hr_mode_enable),
    .regulate(hr_regulation_enable),
    .mul16(hr_multiplier),
    .ref_edge(TCLK_TICK),
    .fast_per_ref(HR_FAST_PER_REF),
    .range_ok_hi(HR_RANGE_OK_HI),
    .range_ok_lo(HR_RANGE_OK_LO),
    .locked(gen_locked),
    .lock_event(gen_lock_ev),
    .fail_hi_event(gen_fh_ev),
    .fail_lo_event(gen_fl_ev)
  );

  // ----------------------------------------
  // Derived values and clock divider
  // ----------------------------------------
  always_comb
  begin
    case (counter_length)
      HRT_LEN8: length_maximum = `HRT_MAX8;
      HRT_LEN10: length_maximum = `HRT_MAX10;
      HRT_LEN12: length_maximum = `HRT_MAX12;
      default: length_maximum = `HRT_MAX16;
    endcase
    eff_period = period_latch;
    if (hr_mode_enable)
    begin
      eff_period = hr_multiplier ? {period_latch[15:4], 4'h0} : {period_latch[15:3], 3'h0};
    end
    wr_ctrl = WR && ADDR == `HRT_OFF_CTRL;
    wr_status = WR && ADDR == `HRT_OFF_STATUS;
    sw_clear = wr_ctrl && WDATA[`HRT_CTRL_CLR_BIT];
    tick = 1'b0;
    next_div_cnt = div_cnt;
    if (TCLK_TICK)
    begin
      if (div_cnt >= ((8'h01 << divider_select) - 8'h01))
      begin
        next_div_cnt = 8'h00;
        tick = 1'b1;
      end
      else
      begin
        next_div_cnt = div_cnt + 8'h01;
      end
    end
    if (sw_clear)
    begin
      next_div_cnt = 8'h00;
    end
  end

  // ----------------------------------------
  // Counter and mode control
  // ----------------------------------------
  always_comb
  begin
    next_count = count;
    next_count_down = count_down;
    ovf_ev = 1'b0;
    cmp_ev = 1'b0;
    // Zero period halts up and up/down; running only with nonzero mode
    if (tick && count_mode_select != HRT_STOP &&
        !(eff_period == 16'h0000 && (count_mode_select == HRT_UP || count_mode_select == HRT_UPDOWN)))
    begin
      case (count_mode_select)
        HRT_UP:
        begin
          next_count_down = 1'b0;
          if (count >= eff_period)
          begin
            next_count = 16'h0000;
            ovf_ev = (count == eff_period);
          end
          else
          begin
            next_count = count + 16'h0001;
            cmp_ev = (count + 16'h0001 == eff_period);
          end
        end
        HRT_UPDOWN:
        begin
          if (eff_period > length_maximum)
          begin
            next_count_down = 1'b0;
            next_count = (count >= length_maximum) ? 16'h0000 : count + 16'h0001;
            ovf_ev = (count >= length_maximum);
          end
          else if (count_down)
          begin
            // A lowered period takes effect once the descent reaches zero
            next_count = count - 16'h0001;
            if (count <= 16'h0001)
            begin
              next_count = 16'h0000;
              next_count_down = 1'b0;
              ovf_ev = (count == 16'h0001);
            end
          end
          else if (count >= eff_period)
          begin
            next_count_down = 1'b1;
            next_count = count - 16'h0001;
          end
          else
          begin
            next_count = count + 16'h0001;
            cmp_ev = (count + 16'h0001 == eff_period);
          end
        end
        default:
        begin
          next_count_down = 1'b0;
          next_count = (count >= length_maximum) ? 16'h0000 : count + 16'h0001;
          ovf_ev = (count >= length_maximum);
          cmp_ev = (count + 16'h0001 == period_latch) && count < length_maximum;
        end
      endcase
    end
    if (WR && ADDR == `HRT_OFF_COUNT)
    begin
      // Direct writes raise no flag
      next_count = WDATA & length_maximum;
      ovf_ev = 1'b0;
      cmp_ev = 1'b0;
    end
    if (WR && ADDR == `HRT_OFF_PERIOD && count_mode_select != HRT_CONT && period_latch == 16'h0000 &&
        WDATA != 16'h0000)
    begin
      next_count = 16'h0000;
      next_count_down = 1'b0;
    end
    if (sw_clear)
    begin
      next_count = 16'h0000;
      next_count_down = 1'b0;
      ovf_ev = 1'b0;
      cmp_ev = 1'b0;
    end
  end

  // ----------------------------------------
  // Register writes, sticky flags and read mux
  // ----------------------------------------
  always_comb
  begin
    next_count_mode_select = count_mode_select;
    next_counter_length = counter_length;
    next_divider_select = divider_select;
    next_period_latch = period_latch;
    next_hr_mode_enable = hr_mode_enable;
    next_hr_regulation_enable = hr_regulation_enable;
    next_hr_multiplier = hr_multiplier;
    next_hr_trim = hr_trim;
    next_hr_subrange = hr_subrange;
    next_hr_range = hr_range;
    if (wr_ctrl)
    begin
      next_count_mode_select = hrt_mode_t'(WDATA[`HRT_CTRL_MODE_LSB +: 2]);
      next_counter_length = hrt_len_t'(WDATA[`HRT_CTRL_LEN_LSB +: 2]);
      next_divider_select = WDATA[`HRT_CTRL_DIV_LSB +: 3];
    end
    if (WR && ADDR == `HRT_OFF_PERIOD)
    begin
      next_period_latch = WDATA;
    end
    if (WR && ADDR == `HRT_OFF_HRCTL)
    begin
      next_hr_mode_enable = WDATA[`HRT_HR_EN_BIT];
      next_hr_regulation_enable = WDATA[`HRT_HR_REG_BIT];
      next_hr_multiplier = WDATA[`HRT_HR_MUL_BIT];
    end
    if (WR && ADDR == `HRT_OFF_HRTUNE)
    begin
      // Tuning fields are kept across regulation on/off
      next_hr_trim = WDATA[`HRT_TUNE_TRIM_LSB +: 7];
      next_hr_subrange = WDATA[`HRT_TUNE_SR_LSB +: 5];
      next_hr_range = WDATA[`HRT_TUNE_R_LSB +: 2];
    end
    // Write one to clear; a same-cycle event wins over the clear
    next_overflow_flag = (overflow_flag && !(wr_status && WDATA[`HRT_ST_OVF_BIT])) || ovf_ev;
    next_channel_zero_compare_flag = (channel_zero_compare_flag && !(wr_status && WDATA[`HRT_ST_CMP_BIT])) || cmp_ev;
    next_hr_lock_flag = (hr_lock_flag && !(wr_status && WDATA[`HRT_ST_LOCK_BIT])) || gen_lock_ev;
    next_hr_fail_high_flag = (hr_fail_high_flag && !(wr_status && WDATA[`HRT_ST_FH_BIT])) || gen_fh_ev;
    next_hr_fail_low_flag = (hr_fail_low_flag && !(wr_status && WDATA[`HRT_ST_FL_BIT])) || gen_fl_ev;
    next_ovf_evt = ovf_ev;
    next_cmp_evt = cmp_ev;
    next_rdata = 16'h0000;
    if (RD)
    begin
      case (ADDR)
        `HRT_OFF_CTRL: next_rdata = {8'h00, divider_select, 1'b0, counter_length, count_mode_select};
        `HRT_OFF_PERIOD: next_rdata = period_latch;
        `HRT_OFF_COUNT: next_rdata = count;
        `HRT_OFF_STATUS: next_rdata = {7'h00, count_down, 2'b00, hr_fail_low_flag, hr_fail_high_flag,
                                      !gen_locked, hr_lock_flag, channel_zero_compare_flag, overflow_flag};
        `HRT_OFF_HRCTL: next_rdata = {13'h0000, hr_multiplier, hr_regulation_enable, hr_mode_enable};
        `HRT_OFF_HRTUNE: next_rdata = {2'b00, hr_range, hr_subrange, hr_trim};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      count_mode_select <= HRT_STOP;
      counter_length <= HRT_LEN16;
      divider_select <= 3'h0;
      period_latch <= 16'h0000;
      count <= 16'h0000;
      count_down <= 1'b0;
      div_cnt <= 8'h00;
      hr_mode_enable <= 1'b0;
      hr_regulation_enable <= 1'b0;
      hr_multiplier <= 1'b0;
      hr_trim <= `HRT_TRIM_RST;
      hr_subrange <= `HRT_SR_RST;
      hr_range <= `HRT_R_RST;
      overflow_flag <= 1'b0;
      channel_zero_compare_flag <= 1'b0;
      hr_lock_flag <= 1'b0;
      hr_fail_high_flag <= 1'b0;
      hr_fail_low_flag <= 1'b0;
      RDATA <= 16'h0000;
      OVERFLOW_EVT <= 1'b0;
      COMPARE0_EVT <= 1'b0;
      EVENT_PENDING <= 1'b0;
      COUNT_OUT <= 16'h0000;
      HR_LOCKED <= 1'b0;
    end
    else
    begin
      count_mode_select <= next_count_mode_select;
      counter_length <= next_counter_length;
      divider_select <= next_divider_select;
      period_latch <= next_period_latch;
      count <= next_count;
      count_down <= next_count_down;
      div_cnt <= next_div_cnt;
      hr_mode_enable <= next_hr_mode_enable;
      hr_regulation_enable <= next_hr_regulation_enable;
      hr_multiplier <= next_hr_multiplier;
      hr_trim <= next_hr_trim;
      hr_subrange <= next_hr_subrange;
      hr_range <= next_hr_range;
      overflow_flag <= next_overflow_flag;
      channel_zero_compare_flag <= next_channel_zero_compare_flag;
      hr_lock_flag <= next_hr_lock_flag;
      hr_fail_high_flag <= next_hr_fail_high_flag;
      hr_fail_low_flag <= next_hr_fail_low_flag;
      RDATA <= next_rdata;
      OVERFLOW_EVT <= next_ovf_evt;
      COMPARE0_EVT <= next_cmp_evt;
      EVENT_PENDING <= next_overflow_flag | next_channel_zero_compare_flag | next_hr_lock_flag |
                       next_hr_fail_high_flag | next_hr_fail_low_flag | (hr_mode_enable & !gen_locked);
      COUNT_OUT <= next_count;
      HR_LOCKED <= gen_locked;
    end
  end
endmodule
`default_nettype wire

//--- tb/hrt_core_monitor.sv
// Port-level assertions for the timer core
`timescale 1ns/1ps
`default_nettype none
`include "hrt_regs.svh"
module hrt_core_monitor
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [`HRT_ADDR_W-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic TCLK_TICK,
  input wire logic [7:0] HR_FAST_PER_REF,
  input wire logic HR_RANGE_OK_HI,
  input wire logic HR_RANGE_OK_LO,
  input wire logic OVERFLOW_EVT,
  input wire logic COMPARE0_EVT,
  input wire logic EVENT_PENDING,
  input wire logic [15:0] COUNT_OUT,
  input wire logic HR_LOCKED
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // ----------------------------------------
  // Counter and events
  // ----------------------------------------
  chk_count_hold: assert property (
    (!TCLK_TICK && !WR) [*3] |-> $stable(COUNT_OUT))
    else $error("count moved without a timer tick");
  // Writes are excluded: they may load any value
  chk_count_step: assert property (
    (!$past(WR) && !$past(WR, 2) && !$past(WR, 3) && $changed(COUNT_OUT)) |->
    (COUNT_OUT == 16'($past(COUNT_OUT) + 16'h0001) ||
     COUNT_OUT == 16'($past(COUNT_OUT) - 16'h0001) || COUNT_OUT == 16'h0000))
    else $error("count jumped by more than one step");
  chk_ovf_cause: assert property (
    OVERFLOW_EVT |-> ($past(TCLK_TICK) || $past(TCLK_TICK, 2) || $past(TCLK_TICK, 3)))
    else $error("overflow without a timer tick");
  chk_cmp_cause: assert property (
    COMPARE0_EVT |-> ($past(TCLK_TICK) || $past(TCLK_TICK, 2) || $past(TCLK_TICK, 3)))
    else $error("compare without a timer tick");
  chk_ovf_single: assert property (OVERFLOW_EVT |=> !OVERFLOW_EVT)
    else $error("overflow pulse longer than one cycle");
  chk_ovf_pend: assert property (OVERFLOW_EVT |-> ##[0:2] EVENT_PENDING)
    else $error("overflow not reported as pending");
  chk_ovf_zero: assert property (OVERFLOW_EVT |-> COUNT_OUT == 16'h0000)
    else $error("overflow while the count is not zero");
  chk_cmp_nonzero: assert property (COMPARE0_EVT |-> COUNT_OUT != 16'h0000)
    else $error("compare while the count is zero");

  // ----------------------------------------
  // Generator and bus
  // ----------------------------------------
  chk_lock_cause: assert property (
    $rose(HR_LOCKED) |-> ($past(TCLK_TICK, 2) || $past(TCLK_TICK, 3) || $past(TCLK_TICK, 4)))
    else $error("lock without a timer tick");
  chk_lock_pend: assert property ($rose(HR_LOCKED) |-> ##[0:2] EVENT_PENDING)
    else $error("lock not reported as pending");
  chk_rd_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside the answer cycle");

  cover property (OVERFLOW_EVT);
  cover property (COMPARE0_EVT);
  cover property ($rose(HR_LOCKED));
endmodule

bind hrt_core hrt_core_monitor mon (.SYS_CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .TCLK_TICK,
  .HR_FAST_PER_REF, .HR_RANGE_OK_HI, .HR_RANGE_OK_LO, .OVERFLOW_EVT, .COMPARE0_EVT,
  .EVENT_PENDING, .COUNT_OUT, .HR_LOCKED);
`default_nettype wire

//--- tb/tb_hires_timer_mode_control.sv
// Self-checking testbench for the timer core
`timescale 1ns/1ps
`default_nettype none
`include "hrt_regs.svh"
module tb_hires_timer_mode_control;
  localparam logic [3:0] A_CTL = `HRT_OFF_CTRL;
  localparam logic [3:0] A_PER = `HRT_OFF_PERIOD;
  localparam logic [3:0] A_CNT = `HRT_OFF_COUNT;
  localparam logic [3:0] A_ST = `HRT_OFF_STATUS;
  localparam logic [3:0] A_HRC = `HRT_OFF_HRCTL;
  localparam logic [3:0] A_HRT = `HRT_OFF_HRTUNE;
  logic SYS_CLK, RST_N, WR, RD, TCLK_TICK, HR_RANGE_OK_HI, HR_RANGE_OK_LO;
  logic [`HRT_ADDR_W-1:0] ADDR;
  logic [15:0] WDATA, RDATA, COUNT_OUT, rv;
  logic [7:0] HR_FAST_PER_REF;
  logic OVERFLOW_EVT, COMPARE0_EVT, EVENT_PENDING, HR_LOCKED;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  hrt_core uut (.SYS_CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .TCLK_TICK, .HR_FAST_PER_REF,
    .HR_RANGE_OK_HI, .HR_RANGE_OK_LO, .OVERFLOW_EVT, .COMPARE0_EVT, .EVENT_PENDING, .COUNT_OUT,
    .HR_LOCKED);

  initial
  begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end

  // ----------------------------------------
  // Bus, tick and report helpers
  // ----------------------------------------
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge SYS_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 rv = RDATA;
    check(rv & m, exp);
  endtask

  // One timer clock edge every two system cycles
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge SYS_CLK);
      TCLK_TICK <= 1'b1;
      @(posedge SYS_CLK);
      TCLK_TICK <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rchk(A_CTL, 16'hFFFF, 16'h0000);
    rchk(A_ST, 16'hFFFF, 16'h0008);
    rchk(A_HRT, 16'hFFFF, 16'h0040);
    wr(4'hF, 16'hFFFF);
    rchk(4'hF, 16'hFFFF, 16'h0000);
    rchk(A_CTL, 16'hFFFF, 16'h0000);
  endtask

  task automatic t_up;
    wr(A_PER, 16'h0005);
    tick(3);
    rchk(A_CNT, 16'hFFFF, 16'h0000);
    wr(A_CTL, 16'h0001);
    tick(2);
    rchk(A_CNT, 16'hFFFF, 16'h0002);
    wr(A_PER, 16'h0000);
    tick(2);
    rchk(A_CNT, 16'hFFFF, 16'h0002);
    wr(A_PER, 16'h0003);
    rchk(A_CNT, 16'hFFFF, 16'h0000);
    wr(A_ST, 16'h0037);
    tick(3);
    rchk(A_ST, 16'h0033, 16'h0002);
    tick(1);
    rchk(A_CNT, 16'hFFFF, 16'h0000);
    tick(1);
    rchk(A_ST, 16'h0033, 16'h0003);
    check({15'h0, EVENT_PENDING}, 16'h0001);
    tick(4);
    rchk(A_CNT, 16'hFFFF, 16'h0001);
    wr(A_ST, 16'h0037);
    wr(A_CNT, 16'h000A);
    tick(1);
    rchk(A_CNT, 16'hFFFF, 16'h0000);
    rchk(A_ST, 16'h0033, 16'h0000);
    wr(A_PER, 16'h000A);
    tick(5);
    rchk(A_CNT, 16'hFFFF, 16'h0005);
    wr(A_PER, 16'h0002);
    tick(1);
    rchk(A_CNT, 16'hFFFF, 16'h0000);
    if (rv !== 16'h0000)
      tick(1);
    rchk(A_CNT, 16'hFFFF, 16'h0000);
  endtask

  task automatic t_cont;
    logic [15:0] mx [4] = '{16'hFFFF, 16'h0FFF, 16'h03FF, 16'h00FF};
    for (int i = 0; i < 4; i++)
    begin
      wr(A_CTL, 16'(2 + 4 * i));
      wr(A_CNT, 16'hFFFF);
      rchk(A_CNT, 16'hFFFF, mx[i]);
      wr(A_ST, 16'h0037);
      tick(1);
      rchk(A_CNT, 16'hFFFF, 16'h0000);
      rchk(A_ST, 16'h0001, 16'h0001);
    end
    wr(A_CNT, 16'h1234);
    rchk(A_CNT, 16'hFFFF, 16'h0034);
    check(COUNT_OUT, 16'h0034);
  endtask

  task automatic t_updown;
    wr(A_CTL, 16'h0013);
    wr(A_ST, 16'h0037);
    tick(2);
    rchk(A_ST, 16'h0033, 16'h0002);
    tick(1);
    rchk(A_ST, 16'h0133, 16'h0102);
    wr(A_CTL, 16'h0000);
    tick(2);
    rchk(A_CNT, 16'hFFFF, 16'h0001);
    wr(A_CTL, 16'h0003);
    tick(1);
    rchk(A_CNT, 16'hFFFF, 16'h0000);
    rchk(A_ST, 16'h0033, 16'h0003);
    // Third tick turns the count downward, so the clear below has a direction to reset
    tick(3);
    wr(A_CTL, 16'h0013);
    rchk(A_ST, 16'h0100, 16'h0000);
    tick(1);
    rchk(A_CNT, 16'hFFFF, 16'h0001);
    wr(A_CTL, 16'h001F);
    wr(A_PER, 16'h0100);
    wr(A_CNT, 16'h00FE);
    wr(A_ST, 16'h0037);
    tick(2);
    rchk(A_CNT, 16'hFFFF, 16'h0000);
    rchk(A_ST, 16'h0001, 16'h0001);
  endtask

  task automatic t_hires;
    for (int m = 0; m < 2; m++)
    begin
      wr(A_HRC, 16'(1 + 4 * m));
      wr(A_CTL, 16'h0001);
      wr(A_PER, m ? 16'h0013 : 16'h000B);
      wr(A_CNT, m ? 16'h000F : 16'h0007);
      wr(A_ST, 16'h0037);
      tick(1);
      rchk(A_ST, 16'h0003, 16'h0002);
      tick(1);
      rchk(A_CNT, 16'hFFFF, 16'h0000);
    end
  endtask

  task automatic t_gen;
    wr(A_CTL, 16'h0000);
    // Move to the next range: subrange to its top, one range step, one subrange step down, then one fine step
    for (int s = 1; s <= 31; s++)
      wr(A_HRT, 16'((s << 7) | 64));
    wr(A_HRT, 16'h1FC0);
    wr(A_HRT, 16'h1F40);
    wr(A_HRT, 16'h1F41);
    HR_FAST_PER_REF <= 8'h10;
    wr(A_HRC, 16'h0003);
    tick(`HRT_LOCK_CYC + 4);
    check({15'h0, HR_LOCKED}, 16'h0000);
    for (int m = 0; m < 2; m++)
    begin
      HR_FAST_PER_REF <= m ? 8'h10 : 8'h08;
      wr(A_HRC, 16'h0001);
      wr(A_ST, 16'h0037);
      wr(A_HRC, 16'(3 + 4 * m));
      tick(`HRT_LOCK_CYC - 1);
      rchk(A_ST, 16'h000C, 16'h0008);
      for (int k = 0; k < 6 && HR_LOCKED !== 1'b1; k++)
        tick(1);
      check({15'h0, HR_LOCKED}, 16'h0001);
      rchk(A_ST, 16'h000C, 16'h0004);
      HR_FAST_PER_REF <= m ? 8'h0F : 8'h07;
      tick(3);
      check({15'h0, HR_LOCKED}, 16'h0001);
      wr(A_HRC, 16'(1 + 4 * m));
      repeat (2) @(posedge SYS_CLK);
      #1;
      check({15'h0, HR_LOCKED}, 16'h0000);
      rchk(A_HRT, 16'hFFFF, 16'h1F41);
    end
    HR_FAST_PER_REF <= 8'h10;
    wr(A_HRC, 16'h0007);
    HR_RANGE_OK_HI <= 1'b0;
    tick(1);
    rchk(A_ST, 16'h0030, 16'h0010);
    HR_RANGE_OK_HI <= 1'b1;
    HR_RANGE_OK_LO <= 1'b0;
    tick(1);
    rchk(A_ST, 16'h0030, 16'h0030);
    HR_RANGE_OK_LO <= 1'b1;
    wr(A_HRC, 16'h0000);
    wr(A_ST, 16'h0037);
    rchk(A_ST, 16'h0037, 16'h0000);
    check({15'h0, EVENT_PENDING}, 16'h0000);
  endtask

  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge SYS_CLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test;
    end
  end

  initial
  begin
    RST_N = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = '0;
    WDATA = 16'h0000;
    TCLK_TICK = 1'b0;
    HR_FAST_PER_REF = 8'h00;
    HR_RANGE_OK_HI = 1'b1;
    HR_RANGE_OK_LO = 1'b1;
    repeat (4) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    t_reset;
    t_up;
    t_cont;
    t_updown;
    t_hires;
    t_gen;
    stop_test;
  end
endmodule
`default_nettype wire
